// ==== verilog/adc_calibration_config_control.sv ====
`timescale 1ns/1ps
module adc_calibration_config_control import adc_cal_pkg::*; #(
	parameter int unsigned CONV_CYCLES [8] = '{rate_cycles(0), rate_cycles(1),
		rate_cycles(2), rate_cycles(3), rate_cycles(4), rate_cycles(5),
		rate_cycles(6), rate_cycles(7)}
) (
	// system clock and reset
	input wire logic clk,
	input wire logic rst,
	// serial port pins
	input wire logic sclk,
	input wire logic selN,
	input wire logic sdi,
	output logic sdo,
	output logic sdoOeN,
	// measurement results from the filter
	input wire logic [23:0] calOffsetRaw,
	input wire logic [25:0] calGainRaw,
	input wire logic [23:0] conversionWord,
	// latch and mode outputs
	output logic [1:0] latchOutputsAnalogPair,
	output logic [3:0] latchOutputsDigitalQuad,
	output logic reducedPowerSelect,
	output logic standbyOrSleepSelect,
	output logic unipolarSelect,
	output logic [2:0] wordRateSelect,
	// coefficients and calibration status
	output logic [23:0] offsetCoef,
	output logic [23:0] gainCoef,
	output logic [1:0] calInputSelect,
	output logic calBusy
);
	link_port_if port ();

	logic [23:0] cfg_reg, cfg_next;
	logic [23:0] offset_reg, offset_next;
	logic [23:0] gain_reg, gain_next;
	logic [23:0] setup_reg, setup_next;
	logic [23:0] rdWord_reg, rdWord_next;
	cal_state_e state_reg, state_next;
	logic [31:0] convCount_reg, convCount_next;
	logic pfPending_reg, pfPending_next;
	logic sdo_reg, sdo_next;
	logic sdoOeN_reg, sdoOeN_next;
	logic [1:0] calSel_reg, calSel_next;
	logic calBusy_reg, calBusy_next;
	logic selSync1_reg, selSync2_reg;
	logic validSync1_reg, validSync2_reg, validSeen_reg;
	logic driveSync1_reg, driveSync2_reg;
	logic readSync1_reg, readSync2_reg;
	logic request;
	logic opWrite;
	logic opRead;
	logic stepEnd;
	logic finish;
	logic [2:0] idx;
	logic [2:0] ccNow;
	logic [23:0] gainSat;

	serial_link_port linkPort (
		.sclk(sclk),
		.selN(selN),
		.sdi(sdi),
		.port(port.link)
	);

	// two-flop synchronisers from the serial clock and pins
	always_ff @(posedge clk) begin
		if (rst) begin
			selSync1_reg <= 1'b1;
			selSync2_reg <= 1'b1;
			validSync1_reg <= 1'b0;
			validSync2_reg <= 1'b0;
			validSeen_reg <= 1'b0;
			driveSync1_reg <= 1'b0;
			driveSync2_reg <= 1'b0;
			readSync1_reg <= 1'b0;
			readSync2_reg <= 1'b0;
		end else begin
			selSync1_reg <= selN;
			selSync2_reg <= selSync1_reg;
			validSync1_reg <= port.cmdValid;
			validSync2_reg <= validSync1_reg;
			validSeen_reg <= validSync2_reg;
			driveSync1_reg <= port.driveBit;
			driveSync2_reg <= driveSync1_reg;
			readSync1_reg <= port.readout;
			readSync2_reg <= readSync1_reg;
		end
	end

	// request decode and saturated gain
	assign request = validSync2_reg & ~validSeen_reg;
	assign opWrite = port.cmdByte[7:6] == OP_WRITE;
	assign opRead = port.cmdByte[7:6] == OP_READ;
	assign idx = port.cmdByte[2:0];
	assign ccNow = cfg_reg[POS_CC +: 3];
	assign gainSat = (calGainRaw[25:24] != 2'h0) ? GAIN_MAX : calGainRaw[23:0];
	assign stepEnd = convCount_reg == CONV_CYCLES[cfg_reg[POS_WR +: 3]] - 32'h1;

	// register access, calibration sequence and port flag
	always_comb begin
		cfg_next = cfg_reg;
		offset_next = offset_reg;
		gain_next = gain_reg;
		setup_next = setup_reg;
		rdWord_next = rdWord_reg;
		state_next = state_reg;
		convCount_next = convCount_reg;
		pfPending_next = pfPending_reg;
		finish = 1'b0;
		if (request && opWrite) begin
			case (idx)
				IDX_OFFSET: offset_next = port.wrWord;
				IDX_GAIN: gain_next = port.wrWord;
				IDX_SETUP: setup_next = port.wrWord;
				IDX_CONFIG: cfg_next = (port.wrWord & CFG_WRITE_MASK) | (cfg_reg & ~CFG_WRITE_MASK);
				default: ;
			endcase
		end
		if (request && opRead) begin
			case (idx)
				IDX_OFFSET: rdWord_next = offset_reg;
				IDX_GAIN: rdWord_next = gain_reg;
				IDX_SETUP: rdWord_next = setup_reg;
				IDX_DATA: rdWord_next = conversionWord;
				IDX_CONFIG: rdWord_next = cfg_reg;
				default: rdWord_next = 24'h000000;
			endcase
			if (idx == IDX_CONFIG) begin
				cfg_next[POS_RV] = 1'b0;
			end else if (idx <= IDX_SETUP) begin
				cfg_next[POS_DF] = 1'b0;
			end
		end
		if (request && port.cmdByte == CMD_NULL) begin
			pfPending_next = 1'b0;
		end
		unique case (state_reg)
			CAL_IDLE: begin
				convCount_next = 32'h0;
				if (ccNow == CC_SELF_OFFSET || ccNow == CC_SYS_OFFSET || ccNow == CC_SELF_BOTH) begin
					state_next = CAL_OFFSET;
				end else if (ccNow == CC_SELF_GAIN || ccNow == CC_SYS_GAIN) begin
					state_next = CAL_GAIN;
				end
			end
			CAL_OFFSET: begin
				convCount_next = convCount_reg + 32'h1;
				if (stepEnd) begin
					offset_next = calOffsetRaw;
					convCount_next = 32'h0;
					if (ccNow == CC_SELF_BOTH) begin
						state_next = CAL_GAIN;
					end else begin
						finish = 1'b1;
					end
				end
			end
			CAL_GAIN: begin
				convCount_next = convCount_reg + 32'h1;
				if (stepEnd) begin
					gain_next = gainSat;
					convCount_next = 32'h0;
					finish = 1'b1;
				end
			end
			default: state_next = CAL_IDLE;
		endcase
		if (finish) begin
			state_next = CAL_IDLE;
			cfg_next[POS_CC +: 3] = CC_NORMAL;
			cfg_next[POS_DF] = 1'b1;
			pfPending_next = 1'b1;
		end
		// held in reset while the reset request bit stands
		if (cfg_reg[POS_RS]) begin
			offset_next = OFFSET_RESET;
			gain_next = GAIN_RESET;
			setup_next = SETUP_RESET;
			state_next = CAL_IDLE;
			convCount_next = 32'h0;
			cfg_next[POS_CC +: 3] = CC_NORMAL;
			cfg_next[POS_RV] = 1'b1;
		end
		// modulator input routing for the coming step
		unique case (state_next)
			CAL_OFFSET: calSel_next = cfg_next[POS_CC + 2] ? SEL_SYSTEM : SEL_SHORTED;
			CAL_GAIN: calSel_next = cfg_next[POS_CC + 2] ? SEL_SYSTEM : SEL_REFERENCE;
			default: calSel_next = SEL_NORMAL;
		endcase
		// busy follows the coming state
		calBusy_next = state_next != CAL_IDLE;
		if (readSync2_reg) begin
			sdo_next = driveSync2_reg;
		end else begin
			sdo_next = cfg_reg[POS_PF] ? ~pfPending_reg : 1'b1;
		end
		sdoOeN_next = selSync2_reg & ~cfg_reg[POS_PF];
	end

	// core registers
	always_ff @(posedge clk) begin
		if (rst) begin
			cfg_reg <= CFG_RESET;
			offset_reg <= OFFSET_RESET;
			gain_reg <= GAIN_RESET;
			setup_reg <= SETUP_RESET;
			rdWord_reg <= 24'h000000;
			state_reg <= CAL_IDLE;
			convCount_reg <= 32'h0;
			pfPending_reg <= 1'b0;
			sdo_reg <= 1'b1;
			sdoOeN_reg <= 1'b1;
			calSel_reg <= SEL_NORMAL;
			calBusy_reg <= 1'b0;
		end else begin
			cfg_reg <= cfg_next;
			offset_reg <= offset_next;
			gain_reg <= gain_next;
			setup_reg <= setup_next;
			rdWord_reg <= rdWord_next;
			state_reg <= state_next;
			convCount_reg <= convCount_next;
			pfPending_reg <= pfPending_next;
			sdo_reg <= sdo_next;
			sdoOeN_reg <= sdoOeN_next;
			calSel_reg <= calSel_next;
			calBusy_reg <= calBusy_next;
		end
	end

	assign latchOutputsAnalogPair = cfg_reg[POS_LATCH_ANALOG +: 2];
	assign latchOutputsDigitalQuad = cfg_reg[POS_LATCH_DIGITAL +: 4];
	// outputs taken straight from registers
	assign reducedPowerSelect = cfg_reg[POS_LPM];
	assign standbyOrSleepSelect = cfg_reg[POS_PSS];
	assign unipolarSelect = cfg_reg[POS_UB];
	assign wordRateSelect = cfg_reg[POS_WR +: 3];
	assign offsetCoef = offset_reg;
	assign gainCoef = gain_reg;
	assign calInputSelect = calSel_reg;
	assign calBusy = calBusy_reg;
	assign sdo = sdo_reg;
	assign sdoOeN = sdoOeN_reg;
	assign port.rdWord = rdWord_reg;
endmodule : adc_calibration_config_control

// ==== verilog/adc_cal_pkg.sv ====
package adc_cal_pkg;
	// configuration word field positions
	localparam int unsigned POS_LATCH_ANALOG = 22;
	localparam int unsigned POS_LATCH_DIGITAL = 18;
	localparam int unsigned POS_LPM = 16;
	localparam int unsigned POS_WR = 13;
	localparam int unsigned POS_UB = 12;
	localparam int unsigned POS_RS = 7;
	localparam int unsigned POS_RV = 6;
	localparam int unsigned POS_PF = 5;
	localparam int unsigned POS_PSS = 4;
	localparam int unsigned POS_DF = 3;
	localparam int unsigned POS_CC = 0;

	// writable bits of the configuration word (unused, reset-seen and done are not)
	localparam logic [23:0] CFG_WRITE_MASK = 24'hfdf0b7;

	// values after reset
	localparam logic [23:0] CFG_RESET = 24'h000000;
	localparam logic [23:0] OFFSET_RESET = 24'h000000;
	localparam logic [23:0] GAIN_RESET = 24'h400000;
	localparam logic [23:0] SETUP_RESET = 24'h000000;
	localparam logic [23:0] GAIN_MAX = 24'hffffff;

	// calibration field codes
	localparam logic [2:0] CC_NORMAL = 3'h0;
	localparam logic [2:0] CC_SELF_OFFSET = 3'h1;
	localparam logic [2:0] CC_SELF_GAIN = 3'h2;
	localparam logic [2:0] CC_SELF_BOTH = 3'h3;
	localparam logic [2:0] CC_SYS_OFFSET = 3'h5;
	localparam logic [2:0] CC_SYS_GAIN = 3'h6;

	// serial command byte layout: op in [7:6], register index in [2:0]
	localparam logic [7:0] CMD_NULL = 8'h00;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [2:0] IDX_OFFSET = 3'h0;
	localparam logic [2:0] IDX_GAIN = 3'h1;
	localparam logic [2:0] IDX_CONFIG = 3'h2;
	localparam logic [2:0] IDX_DATA = 3'h3;
	localparam logic [2:0] IDX_SETUP = 3'h4;

	// frame bit counter marks (count of serial clock edges already seen)
	localparam logic [5:0] CNT_CMD_LAST = 6'h07;
	localparam logic [5:0] CNT_READ_LOAD = 6'h0f;
	localparam logic [5:0] CNT_WRITE_LAST = 6'h1f;
	localparam logic [5:0] CNT_READ_END = 6'h27;
	localparam logic [5:0] CNT_MAX = 6'h28;

	// modulator input selection during calibration
	localparam logic [1:0] SEL_NORMAL = 2'h0;
	localparam logic [1:0] SEL_SHORTED = 2'h1;
	localparam logic [1:0] SEL_REFERENCE = 2'h2;
	localparam logic [1:0] SEL_SYSTEM = 2'h3;

	// word rates in hundredths of samples per second, indexed by rate code
	localparam longint unsigned CLK_HZ = 50_000_000;
	localparam int unsigned RATE_CSPS [8] = '{1500, 3000, 6160, 8450, 10110, 188, 376, 751};

	// one conversion cycle in system clocks for a rate code
	function automatic int unsigned rate_cycles(input int unsigned idx);
		return 32'(CLK_HZ * 100 / longint'(RATE_CSPS[idx]));
	endfunction : rate_cycles

	typedef enum logic [1:0] {
		CAL_IDLE = 2'b00,
		CAL_OFFSET = 2'b01,
		CAL_GAIN = 2'b10
	} cal_state_e;
endpackage : adc_cal_pkg

// ==== verilog/link_port_if.sv ====
`timescale 1ns/1ps
interface link_port_if;
	logic [7:0] cmdByte;
	logic [23:0] wrWord;
	logic cmdValid;
	logic driveBit;
	logic readout;
	logic [23:0] rdWord;

	modport link (output cmdByte, wrWord, cmdValid, driveBit, readout, input rdWord);
	modport core (input cmdByte, wrWord, cmdValid, driveBit, readout, output rdWord);
endinterface : link_port_if

// ==== verilog/serial_link_port.sv ====
`timescale 1ns/1ps
module serial_link_port import adc_cal_pkg::*; (
	// serial pins, serial clock domain
	input wire logic sclk,
	input wire logic selN,
	input wire logic sdi,
	// toward the core
	link_port_if.link port
);
	logic [5:0] bitCount_reg, bitCount_next;
	logic [7:0] cmd_reg, cmd_next;
	logic [23:0] data_reg, data_next;
	logic [23:0] outShift_reg, outShift_next;
	logic cmdValid_reg, cmdValid_next;
	logic driveBit_reg, driveBit_next;
	logic readout_reg, readout_next;
	logic [7:0] newCmd;

	// frame decode: command byte, then write word or read word
	always_comb begin
		bitCount_next = bitCount_reg;
		cmd_next = cmd_reg;
		data_next = data_reg;
		outShift_next = outShift_reg;
		cmdValid_next = cmdValid_reg;
		driveBit_next = driveBit_reg;
		readout_next = readout_reg;
		newCmd = {cmd_reg[6:0], sdi};
		if (bitCount_reg != CNT_MAX) begin
			bitCount_next = bitCount_reg + 6'h01;
		end
		if (bitCount_reg <= CNT_CMD_LAST) begin
			cmd_next = newCmd;
		end
		// null and read requests go to the core after the command byte
		if (bitCount_reg == CNT_CMD_LAST && (newCmd == CMD_NULL || newCmd[7:6] == OP_READ)) begin
			cmdValid_next = 1'b1;
		end
		if (cmd_reg[7:6] == OP_WRITE && bitCount_reg > CNT_CMD_LAST
				&& bitCount_reg <= CNT_WRITE_LAST) begin
			data_next = {data_reg[22:0], sdi};
			if (bitCount_reg == CNT_WRITE_LAST) begin
				cmdValid_next = 1'b1;
			end
		end
		// read word leaves msb first, one bit per rising edge
		if (cmd_reg[7:6] == OP_READ) begin
			if (bitCount_reg == CNT_READ_LOAD) begin
				driveBit_next = port.rdWord[23];
				outShift_next = {port.rdWord[22:0], 1'b0};
				readout_next = 1'b1;
			end else if (bitCount_reg > CNT_READ_LOAD && bitCount_reg < CNT_READ_END) begin
				driveBit_next = outShift_reg[23];
				outShift_next = {outShift_reg[22:0], 1'b0};
			end else if (bitCount_reg == CNT_READ_END) begin
				readout_next = 1'b0;
			end
		end
	end

	// frame state, cleared while the device is not selected
	always_ff @(posedge sclk or posedge selN) begin
		if (selN) begin
			bitCount_reg <= 6'h00;
			cmd_reg <= 8'h00;
			data_reg <= 24'h000000;
			outShift_reg <= 24'h000000;
			cmdValid_reg <= 1'b0;
			driveBit_reg <= 1'b0;
			readout_reg <= 1'b0;
		end else begin
			bitCount_reg <= bitCount_next;
			cmd_reg <= cmd_next;
			data_reg <= data_next;
			outShift_reg <= outShift_next;
			cmdValid_reg <= cmdValid_next;
			driveBit_reg <= driveBit_next;
			readout_reg <= readout_next;
		end
	end

	// command byte and write word held steady until the frame ends, drive bit shifts per edge
	assign port.cmdByte = cmd_reg;
	assign port.wrWord = data_reg;
	assign port.cmdValid = cmdValid_reg;
	assign port.driveBit = driveBit_reg;
	assign port.readout = readout_reg;
endmodule : serial_link_port

// ==== test/adc_cal_props.sv ====
`timescale 1ns/1ps
module adc_cal_props import adc_cal_pkg::*; #(
	parameter int unsigned CONV_CYCLES [8] = '{20, 22, 24, 26, 28, 30, 32, 34}
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// watched outputs and raw inputs
	input wire logic sdo,
	input wire logic sdoOeN,
	input wire logic [23:0] calOffsetRaw,
	input wire logic [25:0] calGainRaw,
	input wire logic [1:0] latchOutputsAnalogPair,
	input wire logic [3:0] latchOutputsDigitalQuad,
	input wire logic [2:0] wordRateSelect,
	input wire logic [23:0] offsetCoef,
	input wire logic [23:0] gainCoef,
	input wire logic [1:0] calInputSelect,
	input wire logic calBusy
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic [1:0] selPrev_reg;
	logic busyPrev_reg;
	int unsigned stepCnt_reg;
	int unsigned stepCnt_next;
	int unsigned stepLen;
	logic stepEnd;
	// length of the running step
	always_comb begin
		stepLen = CONV_CYCLES[wordRateSelect];
		stepEnd = busyPrev_reg && selPrev_reg != SEL_NORMAL
			&& (!calBusy || calInputSelect != selPrev_reg);
		stepCnt_next = !calBusy ? 0 : (calInputSelect == selPrev_reg ? stepCnt_reg + 1 : 1);
	end
	// bookkeeping registers
	always_ff @(posedge clk) begin
		if (rst) begin
			selPrev_reg <= SEL_NORMAL;
			busyPrev_reg <= 1'b0;
			stepCnt_reg <= 0;
		end else begin
			selPrev_reg <= calInputSelect;
			busyPrev_reg <= calBusy;
			stepCnt_reg <= stepCnt_next;
		end
	end
	rst_values_a: assert property ($fell(rst) |-> gainCoef == GAIN_RESET
		&& offsetCoef == OFFSET_RESET && !calBusy
		&& {latchOutputsAnalogPair, latchOutputsDigitalQuad} == 6'h00) else $error("reset values");
	step_len_a: assert property (stepEnd |->
		stepCnt_reg == stepLen) else $error("step length");
	busy_select_a: assert property (calBusy && !$rose(calBusy) |->
		calInputSelect != SEL_NORMAL) else $error("busy without input select");
	select_idle_a: assert property ($fell(calBusy) |->
		##[0:2] calInputSelect == SEL_NORMAL) else $error("input select kept");
	flag_low_a: assert property ($fell(calBusy) && !sdoOeN |-> ##[1:4] !sdo)
		else $error("port flag not low");
	gain_sat_a: assert property ($fell(calBusy) && $past(calInputSelect) == SEL_REFERENCE
		&& calGainRaw[25:24] != 2'h0 |-> ##[0:2] gainCoef == GAIN_MAX) else $error("gain sat");
	gain_load_a: assert property ($fell(calBusy) && $past(calInputSelect) == SEL_REFERENCE
		&& calGainRaw[25:24] == 2'h0 |-> ##[0:2] gainCoef == calGainRaw[23:0])
		else $error("gain load");
	offset_load_a: assert property ($past(calBusy) && $past(calInputSelect) == SEL_SHORTED
		&& calInputSelect != SEL_SHORTED |-> ##[0:2] offsetCoef == calOffsetRaw)
		else $error("offset load");
	step_order_a: assert property (calBusy && $past(calBusy) && $changed(calInputSelect)
		&& $past(calInputSelect) != SEL_NORMAL |-> $past(calInputSelect) == SEL_SHORTED
		&& calInputSelect == SEL_REFERENCE) else $error("step order");
endmodule : adc_cal_props

bind adc_calibration_config_control adc_cal_props #(.CONV_CYCLES(CONV_CYCLES)) adc_cal_props_i (
	.clk, .rst, .sdo, .sdoOeN, .calOffsetRaw, .calGainRaw, .latchOutputsAnalogPair,
	.latchOutputsDigitalQuad, .wordRateSelect, .offsetCoef, .gainCoef, .calInputSelect, .calBusy);

// ==== test/serial_host.sv ====
`timescale 1ns/1ps
module serial_host (
	// serial pins toward the device
	output logic sclk,
	output logic selN,
	output logic sdi,
	input wire logic sdo
);
	// lines idle, link clock stopped
	initial begin
		sclk = 1'b0;
		selN = 1'b1;
		sdi = 1'b0;
	end
	// one frame of n link clocks, reads sampled from edge 17
	task automatic xfer(input logic [7:0] cmd, input logic [23:0] wd, input int n,
		output logic [23:0] rd);
		logic [39:0] sh;
		sh = {cmd, wd, 8'h00};
		rd = 24'h0;
		selN = 1'b0;
		#100;
		for (int k = 1; k <= n; k++) begin
			sdi = sh[39];
			sh = sh << 1;
			#62.5;
			if (k > 16) rd = {rd[22:0], sdo};
			sclk = 1'b1;
			#62.5;
			sclk = 1'b0;
		end
		sdi = ~sdi; // released line shows inverse
		#100;
		selN = 1'b1;
		#150;
	endtask : xfer
	task automatic null_cmd;
		logic [23:0] r;
		xfer(8'h00, 24'h0, 8, r);
	endtask : null_cmd
endmodule : serial_host

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
module tb_top import adc_cal_pkg::*;;
	localparam int unsigned CYC [8] = '{20, 22, 24, 26, 28, 30, 32, 34};
	logic clk, rst, sclk, selN, sdi, sdo, sdoOeN, calBusy;
	logic reducedPowerSelect, standbyOrSleepSelect, unipolarSelect;
	logic [23:0] calOffsetRaw, conversionWord, offsetCoef, gainCoef, cfg;
	logic [25:0] calGainRaw;
	logic [1:0] latchOutputsAnalogPair, calInputSelect;
	logic [3:0] latchOutputsDigitalQuad;
	logic [2:0] wordRateSelect;
	logic [2:0] codes [5] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h6};
	int errCount = 0;
	int nCompared = 0;
	// device and host
	adc_calibration_config_control #(.CONV_CYCLES(CYC)) adc_calibration_config_control_i (
		.clk, .rst, .sclk, .selN, .sdi, .sdo, .sdoOeN, .calOffsetRaw, .calGainRaw,
		.conversionWord, .latchOutputsAnalogPair, .latchOutputsDigitalQuad,
		.reducedPowerSelect, .standbyOrSleepSelect, .unipolarSelect, .wordRateSelect,
		.offsetCoef, .gainCoef, .calInputSelect, .calBusy);
	serial_host serial_host_i (.sclk, .selN, .sdi, .sdo);
	// system clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic wrapUp;
		$display("compared %0d, mismatches %0d", nCompared, errCount);
		if (errCount == 0 && nCompared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : wrapUp
	task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
		nCompared++;
		if (got !== exp) begin
			errCount++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [2:0] idx, input logic [23:0] d);
		logic [23:0] r;
		serial_host_i.xfer({OP_WRITE, 3'h0, idx}, d, 32, r);
	endtask : wr
	task automatic rd(input string nm, input logic [2:0] idx, input logic [23:0] exp);
		logic [23:0] r;
		serial_host_i.xfer({OP_READ, 3'h0, idx}, 24'h0, 40, r);
		chk(nm, exp, r);
	endtask : rd
	// bounded wait for the end of calibration
	task automatic wait_cal;
		for (int i = 0; i < 600; i++) begin
			@(negedge clk);
			if (!calBusy) break;
		end
		repeat (4) @(negedge clk);
		chk("busy", 24'h0, 24'(calBusy));
	endtask : wait_cal
	// watchdog
	initial begin
		#1_000_000;
		errCount++;
		wrapUp();
	end
	// main sequence
	initial begin
		rst = 1'b1;
		calOffsetRaw = 24'h123456;
		calGainRaw = 26'h1abcdef;
		conversionWord = 24'h5a5a5a;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (5) @(posedge clk);
		rd("gain", IDX_GAIN, GAIN_RESET);
		rd("offset", IDX_OFFSET, OFFSET_RESET);
		rd("config", IDX_CONFIG, CFG_RESET);
		wr(IDX_CONFIG, 24'hfd3030);
		chk("pins", 24'h000ff9, {12'h0, latchOutputsAnalogPair, latchOutputsDigitalQuad,
			reducedPowerSelect, unipolarSelect, standbyOrSleepSelect, wordRateSelect});
		rd("cfgback", IDX_CONFIG, 24'hfd3030);
		for (int i = 0; i < 5; i++) begin
			@(posedge clk);
			calGainRaw <= (i == 1) ? 26'h0345678 : 26'h1abcdef;
			wr(IDX_GAIN, 24'h200000);
			wr(IDX_OFFSET, 24'h000001);
			rd("gainw", IDX_GAIN, 24'h200000);
			cfg = 24'h000020 | (24'(i) << 13) | 24'(codes[i]);
			wr(IDX_CONFIG, cfg);
			wait_cal();
			chk("flag", 24'h0, 24'(sdo));
			rd("done", IDX_CONFIG, (cfg & 24'hfffff8) | 24'h8);
			serial_host_i.null_cmd();
			chk("flagclr", 24'h1, 24'(sdo));
			rd("kept", IDX_CONFIG, (cfg & 24'hfffff8) | 24'h8);
			if (codes[i] == CC_SELF_OFFSET || codes[i] == CC_SYS_OFFSET)
				rd("ofs", IDX_OFFSET, 24'h123456);
			else
				rd("gcal", IDX_GAIN, (i == 1) ? 24'h345678 : GAIN_MAX);
			rd("cleared", IDX_CONFIG, cfg & 24'hfffff8);
		end
		wr(IDX_CONFIG, 24'h000024);
		repeat (10) @(negedge clk);
		chk("unused", 24'h0, 24'(calBusy));
		chk("oenpf", 24'h0, 24'(sdoOeN));
		rd("unusedcc", IDX_CONFIG, 24'h000024);
		wr(IDX_CONFIG, 24'h000027);
		repeat (10) @(negedge clk);
		chk("unused7", 24'h0, 24'(calBusy));
		rd("unusedcc7", IDX_CONFIG, 24'h000027);
		rd("data", IDX_DATA, 24'h5a5a5a);
		wr(IDX_SETUP, 24'h00abcd);
		rd("setup", IDX_SETUP, 24'h00abcd);
		// reset request bit holds coefficients at reset values
		wr(IDX_CONFIG, 24'h000080);
		chk("oen", 24'h1, 24'(sdoOeN));
		rd("rstgain", IDX_GAIN, GAIN_RESET);
		rd("rstsetup", IDX_SETUP, SETUP_RESET);
		wr(IDX_CONFIG, 24'h000000);
		rd("rvset", IDX_CONFIG, 24'h000040);
		rd("rvclr", IDX_CONFIG, 24'h000000);
		wrapUp();
	end
endmodule : tb_top
